//--- core/pws_pkg.sv
// Package with constants and types of the wiper serial load block.
package pws_pkg;
  localparam int FRAME_BITS = 10;
  localparam int CODE_BITS  = 8;
  localparam int TAP_COUNT  = 256;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [3:0] CNT_RESET  = 4'h0;
  localparam logic [3:0] CNT_FULL   = 4'ha;
  localparam logic [9:0] SHIFT_RESET = 10'h000;
  localparam logic       ERR_RESET  = 1'b0;
  localparam int         PREFIX_HI  = 9;
  localparam int         PREFIX_LO  = 8;
  typedef struct packed {
    logic select_n;
    logic serial_in;
    logic shift_clock;
  } pws_link_t;
  localparam pws_link_t  LINK_IDLE  = '{1'b1, 1'b0, 1'b0};
endpackage

//--- core/pws_tap_decode.sv
// One-hot decoder from wiper code to resistor tap select.
`timescale 1ns/1ps
module pws_tap_decode #(
  parameter int CODE_W = 8,
  parameter int TAPS   = 256
) (
  input  wire logic [CODE_W-1:0] i_wiper_code,
  output logic      [TAPS-1:0]   o_tap_sel
);
  // Tap 0 sits at terminal B; the top tap stays one step short of A.
  genvar g;
  generate
    for (g = 0; g < TAPS; g++) begin : g_tap
      assign o_tap_sel[g] = (i_wiper_code == CODE_W'(g));
    end
  endgenerate
endmodule

//--- core/pws_serial_load.sv
// Serial load logic of a 256-tap wiper, sampled on the core clock.
// Function
// - Ten bits per frame, last eight are code
// - Shift serial data on shift clock rise
// - Select rise loads code into wiper latch after ten or more bits
// - Code decodes to one of 256 taps
// - Code zero connects wiper to terminal B
// - Code all ones: top tap, not A
// - Higher code moves wiper toward A
`timescale 1ns/1ps
module pws_serial_load #(
  parameter int CODE_W = 8,
  parameter int TAPS   = 256
) (
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_SRST,
  input  wire pws_pkg::pws_link_t I_LINK,
  output logic      [CODE_W-1:0] O_WIPER_CODE,
  output logic      [TAPS-1:0]   O_TAP_SEL,
  output logic                   O_PREFIX_ERR
);
  localparam int FRAME_W = pws_pkg::FRAME_BITS;

  pws_pkg::pws_link_t meta_q;
  pws_pkg::pws_link_t sync_q;
  pws_pkg::pws_link_t last_q;
  logic [FRAME_W-1:0] shift_q;
  logic [FRAME_W-1:0] shift_d;
  logic [3:0]         cnt_q;
  logic [3:0]         cnt_d;
  logic [CODE_W-1:0]  code_q;
  logic [CODE_W-1:0]  code_d;
  logic [TAPS-1:0]    tap_q;
  logic               perr_q;
  logic               perr_d;
  logic [TAPS-1:0]    tap_dec;

  // Rising edge of a synchronised level against its previous sample.
  function automatic logic rose(input logic now_v, input logic was_v);
    return now_v & ~was_v;
  endfunction

  // Two flops guard against metastability; the third keeps the last
  // sample for edge detection and resets to the idle link level.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      meta_q <= pws_pkg::LINK_IDLE;
      sync_q <= pws_pkg::LINK_IDLE;
      last_q <= pws_pkg::LINK_IDLE;
    end else begin
      meta_q <= I_LINK;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  wire clk_rise = rose(sync_q.shift_clock, last_q.shift_clock);
  wire sel_rise = rose(sync_q.select_n, last_q.select_n);
  wire active   = ~sync_q.select_n;
  wire do_shift = active & clk_rise;
  wire cnt_sat  = (cnt_q == pws_pkg::CNT_FULL);
  wire frame_ok = cnt_sat;
  wire load_en  = sel_rise & frame_ok;
  wire [CODE_W-1:0] shift_code = shift_q[CODE_W-1:0];
  wire [1:0]        shift_pfx  =
    shift_q[pws_pkg::PREFIX_HI:pws_pkg::PREFIX_LO];

  // New bits enter at the bottom so the prefix ends up on top.
  assign shift_d = do_shift ? {shift_q[FRAME_W-2:0], sync_q.serial_in}
                            : shift_q;
  assign cnt_d = sel_rise ? pws_pkg::CNT_RESET
               : (do_shift && !cnt_sat) ? cnt_q + 4'h1 : cnt_q;
  assign code_d = load_en ? shift_code : code_q;
  assign perr_d = load_en ? |shift_pfx : perr_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      shift_q <= pws_pkg::SHIFT_RESET;
      cnt_q   <= pws_pkg::CNT_RESET;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
    end
  end

  // A short frame is dropped; more than ten bits keeps the last ten.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      code_q <= pws_pkg::CODE_RESET;
      perr_q <= pws_pkg::ERR_RESET;
    end else begin
      code_q <= code_d;
      perr_q <= perr_d;
    end
  end

  pws_tap_decode #(
    .CODE_W (CODE_W),
    .TAPS   (TAPS)
  ) u_dec (
    .i_wiper_code (code_q),
    .o_tap_sel    (tap_dec)
  );

  // Tap index equals code: 0 is B, 255 one step below A.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      tap_q <= TAPS'(1) << pws_pkg::CODE_RESET;
    end else begin
      tap_q <= tap_dec;
    end
  end

  assign O_WIPER_CODE = code_q;
  assign O_TAP_SEL    = tap_q;
  assign O_PREFIX_ERR = perr_q;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  load_on_rise_a: assert property (
    sel_rise && frame_ok |=> code_q == $past(shift_q[CODE_W-1:0]))
    else $error("code not loaded on select rise");
  hold_idle_a: assert property (
    !sel_rise |=> code_q == $past(code_q))
    else $error("code changed without select rise");
  shift_in_a: assert property (
    do_shift |=> shift_q[0] == $past(sync_q.serial_in))
    else $error("serial bit not shifted in");
  msb_order_a: assert property (
    do_shift |=> shift_q[9:1] == $past(shift_q[8:0]))
    else $error("shift order wrong");
  ignore_high_a: assert property (
    !active |=> shift_q == $past(shift_q))
    else $error("shift while deselected");
  tap_follow_a: assert property (
    1'b1 |=> ##1 $onehot(tap_q))
    else $error("tap select not one-hot");
  zero_b_a: assert property (
    code_q == 8'h00 |=> tap_q[0])
    else $error("code zero not at terminal B");
  top_tap_a: assert property (
    code_q == 8'hff |=> tap_q[TAPS-1])
    else $error("full code not at top tap");
  count_ten_a: assert property (
    sel_rise && !frame_ok |=> code_q == $past(code_q))
    else $error("short frame loaded");
  prefix_flag_a: assert property (
    sel_rise && frame_ok |=> O_PREFIX_ERR == |$past(shift_q[9:8]))
    else $error("prefix flag wrong");

  // The tap select tracks the latched code one cycle later.
  tap_index_a: assert property (
    1'b1 |=> tap_q == (TAPS'(1) << $past(code_q)))
    else $error("tap index differs from code");
  leave_b_a: assert property (
    code_q != '0 |=> !tap_q[0])
    else $error("nonzero code still at terminal B");
  below_top_a: assert property (
    code_q != '1 |=> !tap_q[TAPS-1])
    else $error("top tap set for lower code");
  dec_onehot_a: assert property (
    $onehot(tap_dec))
    else $error("decoder output not one-hot");
  load_out_a: assert property (
    load_en |=> O_WIPER_CODE == $past(shift_code))
    else $error("wiper code port not loaded");
  tap_out_a: assert property (
    load_en |=> ##1 O_TAP_SEL == (TAPS'(1) << $past(shift_code, 2)))
    else $error("tap select port did not follow load");

  // The bit counter counts ten rises and clears on select rise.
  cnt_clear_a: assert property (
    sel_rise |=> cnt_q == pws_pkg::CNT_RESET)
    else $error("bit count not cleared on select rise");
  cnt_step_a: assert property (
    do_shift && !cnt_sat |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("bit count did not step");
  cnt_hold_a: assert property (
    !active && !sel_rise |=> $stable(cnt_q))
    else $error("bit count moved while deselected");
  cnt_limit_a: assert property (
    cnt_q <= pws_pkg::CNT_FULL)
    else $error("bit count beyond frame length");
  cnt_sat_a: assert property (
    cnt_sat && !sel_rise |=> cnt_sat)
    else $error("bit count left saturation");
  shift_keep_a: assert property (
    !do_shift |=> $stable(shift_q))
    else $error("shift register moved without clock rise");

  // The prefix flag moves only when a full frame loads.
  short_perr_a: assert property (
    sel_rise && !frame_ok |=> $stable(perr_q))
    else $error("short frame changed prefix flag");
  perr_hold_a: assert property (
    !load_en |=> $stable(perr_q))
    else $error("prefix flag moved without load");

  // Reset values are checked with the default disable switched off.
  reset_code_a: assert property (
    @(posedge I_CORE_CLK) disable iff (1'b0)
    I_SRST |=> code_q == pws_pkg::CODE_RESET && !perr_q)
    else $error("code or prefix flag not cleared by reset");
  reset_tap_a: assert property (
    @(posedge I_CORE_CLK) disable iff (1'b0)
    I_SRST |=> tap_q == (TAPS'(1) << pws_pkg::CODE_RESET))
    else $error("tap select not at terminal B after reset");
  reset_cnt_a: assert property (
    @(posedge I_CORE_CLK) disable iff (1'b0)
    I_SRST |=> cnt_q == pws_pkg::CNT_RESET)
    else $error("bit count not cleared by reset");

  // Main scenarios: full load, short frame, full code, bad prefix.
  load_cov: cover property (sel_rise && frame_ok);
  short_cov: cover property (sel_rise && !frame_ok);
  full_cov: cover property (code_q == 8'hff);
  perr_cov: cover property (sel_rise && frame_ok && |shift_q[9:8]);
endmodule

//--- testbench/pws_host_model.sv
// Host model that shifts serial frames into the wiper block.
`timescale 1ns/1ps
module pws_host_model (
  input  wire logic          i_clk,
  output pws_pkg::pws_link_t o_link
);
  initial o_link = 3'b100;
  task automatic send(input logic [9:0] w, input int n, input logic s);
    for (int i = n - 1; i >= 0; i--) begin
      o_link <= '{s, w[i], 1'b0};
      repeat (4) @(posedge i_clk);
      o_link.shift_clock <= 1'b1;
      repeat (4) @(posedge i_clk);
    end
    o_link.shift_clock <= 1'b0;
    repeat (4) @(posedge i_clk);
    // Released data line shows the inverse of its last bit.
    o_link <= '{1'b1, ~w[0], 1'b0};
    repeat (8) @(posedge i_clk);
  endtask
endmodule

//--- testbench/pws_serial_load_tb.sv
// Self-checking bench of the wiper serial load block.
`timescale 1ns/1ps
module pws_serial_load_tb;
  logic               clk = 1'b0;
  logic               srst = 1'b1;
  pws_pkg::pws_link_t link;
  logic [7:0]         code;
  logic [255:0]       tap;
  logic               perr;
  logic [7:0]         cur = 8'h00;
  logic               ep = 1'b0;
  int                 n_mismatch = 0;
  int                 tests_run = 0;
  int                 seed = 32'he8ee3745;
  int                 cyc = 0;
  pws_host_model host (.i_clk(clk), .o_link(link));
  pws_serial_load dut (.I_CORE_CLK(clk), .I_SRST(srst), .I_LINK(link),
    .O_WIPER_CODE(code), .O_TAP_SEL(tap), .O_PREFIX_ERR(perr));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [255:0] exp_tap(input logic [7:0] c);
    return 256'h1 << c;
  endfunction
  function automatic logic exp_err(input logic [9:0] f);
    return |f[9:8];
  endfunction
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic frame(input logic [9:0] f, input int n, input logic s);
    host.send(f, n, s);
    if (n == 10 && !s) begin
      cur = f[7:0];
      ep = exp_err(f);
    end
    chk(code, cur);
    chk(tap, exp_tap(cur));
    chk(perr, ep);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(tap, exp_tap(8'h00));
    frame(10'h0ff, 10, 1'b0);
    frame(10'h000, 10, 1'b0);
    frame(10'h081, 10, 1'b0);
    frame(10'h2a5, 10, 1'b0);
    frame(10'h05a, 8, 1'b0);
    frame(10'h03c, 10, 1'b1);
    $display("Corner frames done");
    repeat (20) begin
      frame({2'b00, 8'($random(seed))}, 10, 1'b0);
    end
    $display("Random frames done");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    cur = 8'h00;
    ep = 1'b0;
    chk(code, cur);
    chk(tap, exp_tap(cur));
    chk(perr, ep);
    frame(10'h080, 10, 1'b0);
    $display("Reset frames done");
    give_verdict();
  end
endmodule
